//--- logic/act_top.sv
// Converter control: conversion trigger sequencing, per-channel gain,
// reference select and a clocked serial port to the host.
// Assumes the analog core sits on clk and answers a start with conv_done.
// Functional notes
// - Start conversion on rising trigger edge only
// - Trigger level must persist two converter periods
// - Each channel has its own gain setting
// - Reference selectable among three fixed levels
// - Eight single-ended or four differential channels
// - Conversion starts on converter clock falling edge
// - Results and settings over clocked serial port
module act_top (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               converter_clock,
  input  wire logic               convert_trigger,
  input  wire logic               sclk,
  input  wire logic               sdi,
  input  wire logic               cs_n,
  output logic                    sdo,
  output logic                    sdo_oe_n,
  input  wire logic               conv_done,
  input  wire logic [11:0]        conv_data,
  output logic                    conv_start,
  output logic                    conv_busy,
  output logic [2:0]              conv_chan,
  output logic                    conv_diff,
  output act_pkg::act_gain_t      conv_gain,
  output act_pkg::act_ref_t       conv_ref
);
  import act_pkg::*;

  act_trig_if tif ();

  act_trig u_trig (
    .clk             (clk),
    .reset_n         (reset_n),
    .converter_clock (converter_clock),
    .convert_trigger (convert_trigger),
    .tif             (tif)
  );

  // In differential mode only the four pairs exist
  function automatic logic [2:0] eff_chan(input logic [2:0] ch, input logic diff);
    eff_chan = diff ? {1'b0, ch[1:0]} : ch;
  endfunction

  act_state_t        state_q;
  logic              start_q, busy_q;
  logic [2:0]        chan_q;
  logic              diff_q;
  act_ref_t          ref_q;
  act_gain_t         gain_q [NUM_CH];
  act_gain_t         gain_out_q;
  logic [11:0]       res_data_q;
  logic [2:0]        res_ch_q;
  logic              fresh_q;
  logic              sck_s1_q, sck_s2_q, sck_prev_q;
  logic              sdi_s1_q, sdi_s2_q;
  logic              cs_s1_q, cs_s2_q, cs_prev_q;
  logic [4:0]        bitcnt_q;
  logic [15:0]       rx_q, tx_q;
  logic              fire_q, sdo_q, oe_n_q;
  logic              frame_start, sck_rise, sck_fall, cs_act;
  act_op_t           op;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      start_q <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (tif.trig_qual) begin
            state_q <= ST_ARMED;
            busy_q  <= 1'b1;
          end
        end
        ST_ARMED: begin
          if (tif.converter_clock_fall) begin
            state_q <= ST_BUSY;
            start_q <= 1'b1;
          end
        end
        ST_BUSY: begin
          // Further qualified edges fall through unseen here
          if (conv_done) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // Capture the result; a new result outranks the clear at frame start
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      res_data_q <= DATA_RST;
      res_ch_q   <= CH_RST;
      fresh_q    <= 1'b0;
    end else if (state_q == ST_BUSY && conv_done) begin
      res_data_q <= conv_data;
      res_ch_q   <= chan_q;
      fresh_q    <= 1'b1;
    end else if (frame_start) begin
      fresh_q    <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial port pins, synchronised before use
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sck_s1_q   <= 1'b0;
      sck_s2_q   <= 1'b0;
      sck_prev_q <= 1'b0;
      sdi_s1_q   <= 1'b0;
      sdi_s2_q   <= 1'b0;
      cs_s1_q    <= 1'b1;
      cs_s2_q    <= 1'b1;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_s1_q   <= sclk;
      sck_s2_q   <= sck_s1_q;
      sck_prev_q <= sck_s2_q;
      sdi_s1_q   <= sdi;
      sdi_s2_q   <= sdi_s1_q;
      cs_s1_q    <= cs_n;
      cs_s2_q    <= cs_s1_q;
      cs_prev_q  <= cs_s2_q;
    end
  end

  assign cs_act      = ~cs_s2_q;
  assign frame_start = cs_prev_q & ~cs_s2_q;
  assign sck_rise    = cs_act & sck_s2_q & ~sck_prev_q;
  assign sck_fall    = cs_act & ~sck_s2_q & sck_prev_q;

  // Only clocked framed transfers are understood; bits past 16 are dropped
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bitcnt_q <= BITCNT_RST;
      rx_q     <= WORD_RST;
      fire_q   <= 1'b0;
    end else begin
      fire_q <= 1'b0;
      if (frame_start) begin
        bitcnt_q <= BITCNT_RST;
      end else if (sck_rise && bitcnt_q != FRAME_BITS) begin
        rx_q     <= {rx_q[14:0], sdi_s2_q};
        bitcnt_q <= bitcnt_q + 5'h01;
        fire_q   <= (bitcnt_q == FRAME_LAST);
      end
    end
  end

  // Result word loads at frame start; the host samples on sclk rising
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_q   <= WORD_RST;
      sdo_q  <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= cs_s2_q;
      if (frame_start) begin
        tx_q  <= {res_ch_q, fresh_q, res_data_q};
        sdo_q <= res_ch_q[2];
      end else if (sck_fall) begin
        tx_q  <= {tx_q[14:0], 1'b0};
        sdo_q <= tx_q[14];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command execution
  assign op = act_op_t'(rx_q[CMD_OP_HI:CMD_OP_LO]);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CH; i++) gain_q[i] <= GAIN_RST;
    end else if (fire_q && op == OP_GAIN) begin
      gain_q[rx_q[CMD_CH_HI:CMD_CH_LO]] <= act_gain_t'(rx_q[CMD_GAIN_HI:CMD_GAIN_LO]);
    end
  end

  // An unused reference code leaves the setting as it was
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ref_q  <= REF_RST;
      diff_q <= 1'b0;
      chan_q <= CH_RST;
    end else if (fire_q && op == OP_CFG) begin
      if (rx_q[CMD_REF_HI:CMD_REF_LO] != 2'h3)
        ref_q <= act_ref_t'(rx_q[CMD_REF_HI:CMD_REF_LO]);
      diff_q <= rx_q[CMD_DIFF];
      chan_q <= eff_chan(rx_q[CMD_SEL_HI:CMD_SEL_LO], rx_q[CMD_DIFF]);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) gain_out_q <= GAIN_RST;
    else          gain_out_q <= gain_q[eff_chan(chan_q, diff_q)];
  end

  assign conv_start = start_q;
  assign conv_busy  = busy_q;
  assign conv_chan  = chan_q;
  assign conv_diff  = diff_q;
  assign conv_gain  = gain_out_q;
  assign conv_ref   = ref_q;
  assign sdo        = sdo_q;
  assign sdo_oe_n   = oe_n_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_start_on_fall;
    @(posedge clk) disable iff (!reset_n)
    start_q |-> $past(tif.converter_clock_fall) && $past(state_q) == ST_ARMED;
  endproperty
  a_start_on_fall: assert property (p_start_on_fall) else $error("start not on fall");

  property p_arm_on_qual;
    @(posedge clk) disable iff (!reset_n)
    state_q == ST_IDLE && tif.trig_qual |=> state_q == ST_ARMED && busy_q;
  endproperty
  a_arm_on_qual: assert property (p_arm_on_qual) else $error("qualified edge not taken");

  // Busy may only open while the debounced trigger level is high
  property p_busy_level;
    @(posedge clk) disable iff (!reset_n)
    $rose(busy_q) |-> tif.trig_level;
  endproperty
  a_busy_level: assert property (p_busy_level) else $error("busy without high trigger");

  property p_ignore_busy;
    @(posedge clk) disable iff (!reset_n)
    state_q == ST_BUSY && !conv_done |=> state_q == ST_BUSY && !start_q;
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("conversion disturbed");

  property p_gain_write;
    @(posedge clk) disable iff (!reset_n)
    fire_q && op == OP_GAIN
      |=> gain_q[$past(rx_q[CMD_CH_HI:CMD_CH_LO])] == $past(rx_q[CMD_GAIN_HI:CMD_GAIN_LO]);
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain not stored");

  property p_ref_legal;
    @(posedge clk) disable iff (!reset_n)
    ref_q inside {REF_1V15, REF_2V048, REF_2V5};
  endproperty
  a_ref_legal: assert property (p_ref_legal) else $error("illegal reference");

  property p_diff_chan;
    @(posedge clk) disable iff (!reset_n)
    diff_q |-> !chan_q[2];
  endproperty
  a_diff_chan: assert property (p_diff_chan) else $error("diff channel out of range");

  property p_frame_tag;
    @(posedge clk) disable iff (!reset_n)
    frame_start && !(state_q == ST_BUSY && conv_done)
      |=> tx_q[RES_CH_HI:RES_CH_LO] == $past(res_ch_q) && !fresh_q;
  endproperty
  a_frame_tag: assert property (p_frame_tag) else $error("result word not loaded");

  property p_oe_follow;
    @(posedge clk) disable iff (!reset_n)
    !cs_s2_q [*2] |-> !oe_n_q;
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("output not driven in frame");

  c_start: cover property (@(posedge clk) disable iff (!reset_n) start_q);
  c_gain:  cover property (@(posedge clk) disable iff (!reset_n) fire_q && op == OP_GAIN);
  c_cfg:   cover property (@(posedge clk) disable iff (!reset_n) fire_q && op == OP_CFG);
  c_fresh: cover property (@(posedge clk) disable iff (!reset_n) frame_start && fresh_q);

endmodule

//--- include/act_pkg.sv
// Shared constants and types for the converter trigger and configuration block.
// Assumes a 40 MHz system clock; the trigger, converter clock and serial port pins are asynchronous to it.
package act_pkg;

  // Trigger debounce: the new level must hold over this many converter clock periods
  localparam logic [1:0] DEB_PERIODS = 2'h2;
  localparam logic [1:0] DEB_CNT_RST = 2'h0;

  // Serial frame: 16 bits, most significant first
  localparam logic [4:0] FRAME_BITS  = 5'h10;
  localparam logic [4:0] FRAME_LAST  = 5'h0F;
  localparam logic [4:0] BITCNT_RST  = 5'h00;
  localparam int         CMD_OP_HI   = 15;
  localparam int         CMD_OP_LO   = 14;
  localparam int         CMD_CH_HI   = 13;
  localparam int         CMD_CH_LO   = 11;
  localparam int         CMD_GAIN_HI = 2;
  localparam int         CMD_GAIN_LO = 0;
  localparam int         CMD_REF_HI  = 1;
  localparam int         CMD_REF_LO  = 0;
  localparam int         CMD_DIFF    = 2;
  localparam int         CMD_SEL_HI  = 5;
  localparam int         CMD_SEL_LO  = 3;

  // Result word layout
  localparam int         RES_CH_HI   = 15;
  localparam int         RES_CH_LO   = 13;
  localparam int         RES_FRESH   = 12;
  localparam int         RES_DATA_HI = 11;
  localparam int         DATA_W      = 12;
  localparam int         NUM_CH      = 8;

  localparam logic [2:0]  CH_RST     = 3'h0;
  localparam logic [11:0] DATA_RST   = 12'h000;
  localparam logic [15:0] WORD_RST   = 16'h0000;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_GAIN = 2'h1,
    OP_CFG  = 2'h2,
    OP_NOP  = 2'h3
  } act_op_t;

  typedef enum logic [2:0] {
    GAIN_1  = 3'h0,
    GAIN_2  = 3'h1,
    GAIN_4  = 3'h2,
    GAIN_5  = 3'h3,
    GAIN_8  = 3'h4,
    GAIN_10 = 3'h5,
    GAIN_16 = 3'h6,
    GAIN_20 = 3'h7
  } act_gain_t;

  typedef enum logic [1:0] {
    REF_1V15  = 2'h0,
    REF_2V048 = 2'h1,
    REF_2V5   = 2'h2
  } act_ref_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_BUSY  = 3'b100
  } act_state_t;

  localparam act_gain_t GAIN_RST = GAIN_1;
  localparam act_ref_t  REF_RST  = REF_2V5;

endpackage

//--- include/act_trig_if.sv
// Events passed from the trigger front end to the conversion control.
// All signals are single-cycle pulses or levels on the system clock.
interface act_trig_if;
  logic converter_clock_fall;
  logic trig_qual;
  logic trig_level;

  modport src (output converter_clock_fall, output trig_qual, output trig_level);
  modport dst (input  converter_clock_fall, input  trig_qual, input  trig_level);
endinterface

//--- logic/act_trig.sv
// Trigger front end: synchronises the converter clock and trigger pins,
// debounces the trigger in converter clock periods and flags rising edges.
// Assumes both pins are asynchronous to clk and far slower than it.
module act_trig (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic converter_clock,
  input  wire logic convert_trigger,
  act_trig_if.src   tif
);
  import act_pkg::*;

  logic       cc_s1_q, cc_s2_q, cc_prev_q;
  logic       tr_s1_q, tr_s2_q;
  logic       stable_q;
  logic [1:0] cnt_q;
  logic       qual_q, fall_q;
  logic       cc_rise;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cc_s1_q   <= 1'b0;
      cc_s2_q   <= 1'b0;
      cc_prev_q <= 1'b0;
      tr_s1_q   <= 1'b0;
      tr_s2_q   <= 1'b0;
    end else begin
      cc_s1_q   <= converter_clock;
      cc_s2_q   <= cc_s1_q;
      cc_prev_q <= cc_s2_q;
      tr_s1_q   <= convert_trigger;
      tr_s2_q   <= tr_s1_q;
    end
  end

  assign cc_rise = cc_s2_q & ~cc_prev_q;

  always_ff @(posedge clk) begin
    if (!reset_n) fall_q <= 1'b0;
    else          fall_q <= ~cc_s2_q & cc_prev_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Level is judged only at converter clock rising edges, so glitches
  // shorter than a period never reach the stable level
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stable_q <= 1'b0;
      cnt_q    <= DEB_CNT_RST;
      qual_q   <= 1'b0;
    end else begin
      qual_q <= 1'b0;
      if (cc_rise) begin
        if (tr_s2_q != stable_q) begin
          if (cnt_q + 2'h1 == DEB_PERIODS) begin
            stable_q <= tr_s2_q;
            cnt_q    <= DEB_CNT_RST;
            qual_q   <= tr_s2_q;
          end else begin
            cnt_q <= cnt_q + 2'h1;
          end
        end else begin
          cnt_q <= DEB_CNT_RST;
        end
      end
    end
  end

  assign tif.converter_clock_fall  = fall_q;
  assign tif.trig_qual  = qual_q;
  assign tif.trig_level = stable_q;

  ////////////////////////////////////////////////////////////////////////////
  property p_qual_rising;
    @(posedge clk) disable iff (!reset_n)
    qual_q |-> stable_q && !$past(stable_q);
  endproperty
  a_qual_rising: assert property (p_qual_rising) else $error("qualified edge not rising");

  property p_deb_two;
    @(posedge clk) disable iff (!reset_n)
    $changed(stable_q) |-> $past(cnt_q) == DEB_PERIODS - 2'h1 && $past(cc_rise);
  endproperty
  a_deb_two: assert property (p_deb_two) else $error("level accepted too early");

  property p_no_fall_start;
    @(posedge clk) disable iff (!reset_n)
    $fell(stable_q) |-> !qual_q;
  endproperty
  a_no_fall_start: assert property (p_no_fall_start) else $error("falling edge qualified");

  c_qual: cover property (@(posedge clk) disable iff (!reset_n) qual_q);

endmodule

//--- tb/act_host_model.sv
// Host side of the clocked serial port: mode 0, 16-bit frames, MSB first.
// Assumes clk is the device clock; pins change 1 ns after its rising edge, sdi 2 ns for bits after the first.
module act_host_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      sdi,
  output logic      cs_n,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  logic sdo_last;
  logic sdo_w;

  initial begin
    sclk = 1'b0;
    sdi  = 1'b0;
    cs_n = 1'b1;
  end

  // Released line shows the inverse of its last value, never a lucky match
  always @(posedge clk) begin
    if (!sdo_oe_n) begin
      sdo_last <= sdo;
    end
  end
  assign sdo_w = !sdo_oe_n ? sdo : ~sdo_last;

  //////////////////////////////////////////////////////////////////////////
  // Synchronous frame only; the port is never run asynchronously
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
    int i;
    @(posedge clk) #1 cs_n = 1'b0;
    repeat (8) @(posedge clk);
    for (i = 15; i >= 0; i--) begin
      #1 sdi = cmd[i];
      repeat (5) @(posedge clk);
      #1 sclk = 1'b1;
      rsp[i] = sdo_w;
      repeat (5) @(posedge clk);
      #1 sclk = 1'b0;
    end
    repeat (8) @(posedge clk);
    #1 cs_n = 1'b1;
    sdi = ~sdi;
    repeat (8) @(posedge clk);
  endtask
endmodule

//--- tb/test_adc_trigger_and_config.sv
// Self-checking bench for act_top: trigger, gain, reference, mux, readback.
// Assumes act_host_model plays the host; the bench plays trigger and core.
module test_adc_trigger_and_config;
  timeunit 1ns;
  timeprecision 100ps;
  import act_pkg::*;

  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        converter_clock = 1'b0;
  logic        convert_trigger = 1'b0;
  logic        conv_done = 1'b0;
  logic [11:0] conv_data = 12'h000;
  logic        sclk, sdi, cs_n, sdo, sdo_oe_n;
  logic        conv_start, conv_busy, conv_diff, cc_d;
  logic [2:0]  conv_chan;
  act_gain_t   conv_gain;
  act_ref_t    conv_ref;
  logic [15:0] rsp;
  int          err_total = 0;
  int          checked = 0;
  int          start_cnt = 0;
  int          since_fall = 0;
  int          fall_at_start = 0;

  always #12.5 clk = ~clk;
  always #100 converter_clock = ~converter_clock;

  act_top DUT (.clk(clk), .reset_n(reset_n), .converter_clock(converter_clock),
    .convert_trigger(convert_trigger), .sclk(sclk), .sdi(sdi), .cs_n(cs_n),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n), .conv_done(conv_done), .conv_data(conv_data),
    .conv_start(conv_start), .conv_busy(conv_busy), .conv_chan(conv_chan),
    .conv_diff(conv_diff), .conv_gain(conv_gain), .conv_ref(conv_ref));

  act_host_model HOST (.clk(clk), .sclk(sclk), .sdi(sdi), .cs_n(cs_n),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n));

  // Start pulses counted, with cycles since the last converter clock fall
  always @(posedge clk) begin
    cc_d <= converter_clock;
    since_fall <= (cc_d && !converter_clock) ? 0 : since_fall + 1;
    if (conv_start === 1'b1) begin
      start_cnt <= start_cnt + 1;
      fall_at_start <= since_fall;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Trigger source keeps each level at least two converter periods
  task automatic trig(input logic lvl, input int periods);
    @(posedge clk) #1 convert_trigger = lvl;
    repeat (periods * 8) @(posedge clk);
  endtask

  task automatic wait_start(input int base);
    int n;
    n = 0;
    while (start_cnt == base && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n == 400) begin
      err_total++;
      end_of_test();
    end
  endtask

  task automatic core_done(input logic [11:0] d);
    @(posedge clk) #1 conv_done = 1'b1;
    conv_data = d;
    @(posedge clk) #1 conv_done = 1'b0;
    conv_data = ~d;
    repeat (2) @(posedge clk);
  endtask

  task automatic cfg(input logic [2:0] ch, input logic diff, input logic [1:0] r);
    HOST.xfer({2'h2, 8'h00, ch, diff, r}, rsp);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({13'h0, GAIN_1}, {13'h0, conv_gain});
    chk({14'h0, REF_2V5}, {14'h0, conv_ref});
    chk(16'h0001, {12'h0, conv_start, conv_busy, conv_diff, sdo_oe_n});
    chk(16'h0000, {13'h0, conv_chan});
  endtask

  // Every gain code, each on its own channel, read back per channel
  task automatic t_gain();
    int i;
    for (i = 0; i < 8; i++) begin
      HOST.xfer({2'h1, i[2:0], 8'h00, i[2:0]}, rsp);
    end
    for (i = 7; i >= 0; i--) begin
      cfg(i[2:0], 1'b0, 2'h2);
      chk({13'h0, i[2:0]}, {13'h0, conv_gain});
      chk({13'h0, i[2:0]}, {13'h0, conv_chan});
    end
  endtask

  // All reference levels, then the unused code must leave the last one
  task automatic t_ref();
    int r;
    for (r = 0; r < 3; r++) begin
      cfg(3'h1, 1'b0, r[1:0]);
      chk({14'h0, r[1:0]}, {14'h0, conv_ref});
    end
    cfg(3'h1, 1'b0, 2'h3);
    chk({14'h0, REF_2V5}, {14'h0, conv_ref});
    // A no-op frame whose body would alter gain, reference and channel
    HOST.xfer({OP_NOP, 14'h083C}, rsp);
    chk({14'h0, REF_2V5}, {14'h0, conv_ref});
    chk({12'h0, 1'b0, 3'h1}, {12'h0, conv_diff, conv_chan});
    chk({13'h0, GAIN_2}, {13'h0, conv_gain});
  endtask

  // Differential mode folds channel 6 onto pair 2, gain follows the pair
  task automatic t_diff();
    cfg(3'h6, 1'b1, 2'h1);
    chk({12'h0, 1'b1, 3'h2}, {12'h0, conv_diff, conv_chan});
    chk({13'h0, GAIN_4}, {13'h0, conv_gain});
    cfg(3'h5, 1'b0, 2'h2);
    chk({12'h0, 1'b0, 3'h5}, {12'h0, conv_diff, conv_chan});
  endtask

  task automatic t_trig();
    int base;
    base = start_cnt;
    trig(1'b0, 3);
    trig(1'b1, 3);
    wait_start(base);
    chk(16'h0001, {15'h0, (fall_at_start <= 5)});
    chk(16'h0001, {15'h0, conv_busy});
    core_done(12'hA5C);
    chk(16'h0000, {15'h0, conv_busy});
    HOST.xfer(16'h0000, rsp);
    chk({3'h5, 1'b1, 12'hA5C}, rsp);
    HOST.xfer(16'h0000, rsp);
    chk({3'h5, 1'b0, 12'hA5C}, rsp);
    chk({14'h0, REF_2V5}, {14'h0, conv_ref});
  endtask

  // Falling edge, then a pulse shorter than one converter period
  task automatic t_fall_short();
    int base;
    base = start_cnt;
    trig(1'b0, 4);
    @(posedge clk) #1 convert_trigger = 1'b1;
    repeat (4) @(posedge clk);
    trig(1'b0, 4);
    chk(base[15:0], start_cnt[15:0]);
  endtask

  // A second qualified edge while busy must not restart the converter
  task automatic t_busy();
    int base;
    base = start_cnt;
    trig(1'b1, 3);
    wait_start(base);
    trig(1'b0, 3);
    trig(1'b1, 3);
    chk(base[15:0] + 16'h1, start_cnt[15:0]);
    chk(16'h0001, {15'h0, conv_busy});
    core_done(12'h3F1);
    chk(16'h0000, {15'h0, conv_busy});
    trig(1'b0, 3);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_gain();
    t_ref();
    t_diff();
    t_trig();
    t_fall_short();
    t_busy();
    end_of_test();
  end
endmodule
